/* File: smc_pkg.sv */
package smc_pkg;
    localparam int          CLK_PERIOD_PS   = 5000;
    localparam logic [7:0]  SLEEP_CTRL_ADDR = 8'h33;
    localparam int          CTRL_W          = 4;
    localparam int          CTRL_SE_BIT     = 0;
    localparam int          CTRL_MODE_LSB   = 1;
    localparam int          CTRL_MODE_MSB   = 3;
    localparam logic [3:0]  CTRL_RESET      = 4'h0;
    localparam logic [15:0] HOLD_CYC        = 16'h0004;
    localparam logic [15:0] STBY_WAKE_CYC   = 16'h0006;
    localparam int          STARTUP_FAST_NS = 1000;
    localparam int          STARTUP_SLOW_NS = 65000;
    localparam int STARTUP_FAST_CYC = (STARTUP_FAST_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int STARTUP_SLOW_CYC = (STARTUP_SLOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int          CKSRC_W         = 4;
    localparam logic [3:0]  XTAL_FUSE_MIN   = 4'h8;
    localparam int          SLOW_FUSE_BIT   = 0;
    // Clock and oscillator enable vector
    localparam int CE_CORE   = 0;
    localparam int CE_PROG   = 1;
    localparam int CE_PERIPH = 2;
    localparam int CE_CONV   = 3;
    localparam int CE_ASYNC  = 4;
    localparam int CE_MOSC   = 5;
    localparam int CE_TOSC   = 6;
    localparam int CE_T2SYNC = 7;
    localparam int CE_W      = 8;
    localparam logic [7:0] CE_ALL = 8'hFF;
    // Wake request vector
    localparam int WK_EXT0    = 0;
    localparam int WK_PCINT   = 3;
    localparam int WK_TWMATCH = 4;
    localparam int WK_TWIRQ   = 5;
    localparam int WK_WDTIRQ  = 6;
    localparam int WK_CONV    = 7;
    localparam int WK_NVM     = 8;
    localparam int WK_T2OVF   = 9;
    localparam int WK_T2CMP   = 10;
    localparam int WK_OTHER   = 11;
    localparam int WK_EXTRST  = 12;
    localparam int WK_WDTRST  = 13;
    localparam int WK_BODRST  = 14;
    localparam int WK_W       = 15;

    typedef enum logic [2:0] {
        MODE_IDLE  = 3'b000,
        MODE_QUIET = 3'b001,
        MODE_PDOWN = 3'b010,
        MODE_PSAVE = 3'b011,
        MODE_RSV4  = 3'b100,
        MODE_RSV5  = 3'b101,
        MODE_STBY  = 3'b110,
        MODE_ESTBY = 3'b111
    } smc_mode_t;

    typedef enum logic [1:0] {
        ST_ACTIVE = 2'b00,
        ST_SLEEP  = 2'b01,
        ST_START  = 2'b10,
        ST_HOLD   = 2'b11
    } smc_state_t;
endpackage : smc_pkg

/* File: smc_sleep_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
module smc_sleep_ctrl #(
    parameter logic [15:0] STARTUP_FAST = 16'(smc_pkg::STARTUP_FAST_CYC),
    parameter logic [15:0] STARTUP_SLOW = 16'(smc_pkg::STARTUP_SLOW_CYC)
) (
    input  wire logic                          core_clk,
    input  wire logic                          rst_n,
    input  wire logic                          ctrlWrEn,
    input  wire logic [7:0]                    ctrlWrData,
    output logic      [7:0]                    ctrlRdData,
    input  wire logic                          sleepInstr,
    input  wire logic [smc_pkg::CKSRC_W-1:0]   clockSourceFuses,
    input  wire logic                          converterEnabled,
    input  wire logic                          asyncTimerIsAsync,
    input  wire logic                          asyncTimerIsSync,
    input  wire logic [1:0]                    asyncTimerIrqMask,
    input  wire logic                          globalIrqEn,
    input  wire logic [2:0]                    extIrqIsLevel,
    input  wire logic [2:0]                    extIrqLines,
    input  wire logic                          pinChangeIrq,
    input  wire logic                          twoWireMatch,
    input  wire logic                          twoWireIrq,
    input  wire logic                          watchdogIrq,
    input  wire logic                          convDoneIrq,
    input  wire logic                          nvReadyIrq,
    input  wire logic                          asyncTimerOvf,
    input  wire logic                          asyncTimerCmp,
    input  wire logic                          otherIrq,
    input  wire logic                          extResetReq,
    input  wire logic                          watchdogResetReq,
    input  wire logic                          brownOutResetReq,
    output logic                               coreClkEn,
    output logic                               progClkEn,
    output logic                               periphClkEn,
    output logic                               convClkEn,
    output logic                               asyncClkEn,
    output logic                               mainOscEn,
    output logic                               timerOscEn,
    output logic                               timerSyncClkEn,
    output logic                               coreHalt,
    output logic                               sleeping,
    output logic                               convStart,
    output logic                               wakeIrq,
    output logic                               resetReq
);
    import smc_pkg::*;

    typedef struct packed {
        smc_state_t          state;
        logic [CTRL_W-1:0]   ctrl;
        smc_mode_t           mode;
        logic [15:0]         cnt;
        logic                byReset;
        logic                convStart;
        logic                wakeIrq;
        logic                resetReq;
        logic [WK_W-1:0]     syncA;
        logic [WK_W-1:0]     syncB;
    } smc_regs_t;

    smc_regs_t r_reg;
    smc_regs_t r_next;

    logic [WK_W-1:0] wakeRaw;
    logic [WK_W-1:0] wk;
    logic            xtalSel;
    logic            t2Wake;
    logic            extLevelWake;
    logic            extAnyWake;
    logic            rstWake;
    logic            irqWake;
    logic            sleepOk;
    smc_mode_t       selMode;
    logic [CE_W-1:0] gate;

    // Clock gating per sleep mode, bit order as CE_* indices
    function automatic logic [CE_W-1:0] modeGates(input smc_mode_t m, input logic tAsync,
                                                  input logic tSync);
        logic [CE_W-1:0] g;
        g = '0;
        case (m)
            MODE_IDLE: begin
                g = CE_ALL;
                g[CE_CORE] = 1'b0;
                g[CE_PROG] = 1'b0;
                g[CE_T2SYNC] = 1'b0;
                g[CE_TOSC] = tAsync;
            end
            MODE_QUIET: begin
                g[CE_CONV] = 1'b1;
                g[CE_ASYNC] = 1'b1;
                g[CE_MOSC] = 1'b1;
                g[CE_TOSC] = tAsync;
            end
            MODE_PSAVE, MODE_ESTBY: begin
                g[CE_ASYNC] = tAsync;
                g[CE_TOSC] = tAsync;
                g[CE_T2SYNC] = tSync & (m == MODE_PSAVE);
                g[CE_MOSC] = tSync | (m == MODE_ESTBY);
            end
            MODE_STBY: begin
                g[CE_MOSC] = 1'b1;
            end
            default: begin
                g = '0;
            end
        endcase
        return g;
    endfunction : modeGates

    // Wake inputs come from pins and unclocked logic
    assign wakeRaw = {brownOutResetReq, watchdogResetReq, extResetReq, otherIrq,
                      asyncTimerCmp, asyncTimerOvf, nvReadyIrq, convDoneIrq,
                      watchdogIrq, twoWireIrq, twoWireMatch, pinChangeIrq, extIrqLines};
    assign wk = r_reg.syncB;

    // Wake condition decode
    always_comb begin
        xtalSel = (clockSourceFuses >= XTAL_FUSE_MIN);
        selMode = smc_mode_t'(r_reg.ctrl[CTRL_MODE_MSB:CTRL_MODE_LSB]);
        t2Wake = globalIrqEn & ((wk[WK_T2OVF] & asyncTimerIrqMask[0]) |
                                (wk[WK_T2CMP] & asyncTimerIrqMask[1]));
        extAnyWake = |wk[WK_EXT0 +: 3];
        extLevelWake = |(wk[WK_EXT0 +: 3] & extIrqIsLevel);
        rstWake = wk[WK_EXTRST] | wk[WK_WDTRST] | wk[WK_BODRST];
        sleepOk = r_reg.ctrl[CTRL_SE_BIT];
        if (selMode == MODE_RSV4 || selMode == MODE_RSV5) begin
            sleepOk = 1'b0;
        end else if ((selMode == MODE_STBY || selMode == MODE_ESTBY) && !xtalSel) begin
            sleepOk = 1'b0;
        end
        case (r_reg.mode)
            MODE_IDLE: begin
                irqWake = extAnyWake | (|wk[WK_OTHER:WK_PCINT]);
            end
            MODE_QUIET: begin
                irqWake = extLevelWake | wk[WK_PCINT] | wk[WK_TWMATCH] |
                          wk[WK_TWIRQ] | wk[WK_WDTIRQ] | wk[WK_CONV] |
                          wk[WK_NVM] | t2Wake;
            end
            MODE_PSAVE, MODE_ESTBY: begin
                irqWake = extLevelWake | wk[WK_PCINT] | wk[WK_TWMATCH] |
                          wk[WK_WDTIRQ] | t2Wake;
            end
            default: begin
                irqWake = extLevelWake | wk[WK_PCINT] | wk[WK_TWMATCH] |
                          wk[WK_WDTIRQ];
            end
        endcase
        gate = modeGates(r_reg.mode, asyncTimerIsAsync, asyncTimerIsSync);
    end

    // Next-state logic
    always_comb begin
        r_next = r_reg;
        r_next.syncA = wakeRaw;
        r_next.syncB = r_reg.syncA;
        r_next.convStart = 1'b0;
        r_next.wakeIrq = 1'b0;
        r_next.resetReq = 1'b0;
        if (ctrlWrEn) begin
            r_next.ctrl = ctrlWrData[CTRL_W-1:0];
        end
        case (r_reg.state)
            ST_ACTIVE: begin
                if (sleepInstr && sleepOk) begin
                    r_next.state = ST_SLEEP;
                    r_next.mode = selMode;
                    r_next.convStart = converterEnabled &&
                        (selMode == MODE_IDLE || selMode == MODE_QUIET);
                end
            end
            ST_SLEEP: begin
                if (rstWake || irqWake) begin
                    r_next.byReset = rstWake;
                    if (r_reg.mode == MODE_IDLE || r_reg.mode == MODE_QUIET) begin
                        r_next.state = ST_HOLD;
                        r_next.cnt = HOLD_CYC - 16'h0001;
                    end else if (r_reg.mode == MODE_STBY || r_reg.mode == MODE_ESTBY) begin
                        r_next.state = ST_START;
                        r_next.cnt = STBY_WAKE_CYC - 16'h0001;
                    end else begin
                        r_next.state = ST_START;
                        r_next.cnt = (clockSourceFuses[SLOW_FUSE_BIT] ? STARTUP_SLOW
                                      : STARTUP_FAST) - 16'h0001;
                    end
                end
            end
            ST_START: begin
                if (r_reg.cnt != 16'h0000) begin
                    r_next.cnt = r_reg.cnt - 16'h0001;
                end else begin
                    r_next.state = ST_HOLD;
                    r_next.cnt = HOLD_CYC - 16'h0001;
                end
            end
            ST_HOLD: begin
                if (r_reg.cnt != 16'h0000) begin
                    r_next.cnt = r_reg.cnt - 16'h0001;
                end else begin
                    r_next.state = ST_ACTIVE;
                    r_next.byReset = 1'b0;
                    r_next.resetReq = r_reg.byReset;
                    r_next.wakeIrq = !r_reg.byReset;
                    if (r_reg.byReset) begin
                        r_next.ctrl = CTRL_RESET;
                    end
                end
            end
            default: begin
                r_next.state = ST_ACTIVE;
            end
        endcase
    end

    // State register; a wake by a reset source clears the control bits
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            r_reg.state <= ST_ACTIVE;
            r_reg.ctrl <= CTRL_RESET;
            r_reg.mode <= MODE_IDLE;
            r_reg.cnt <= 16'h0000;
            r_reg.byReset <= 1'b0;
            r_reg.convStart <= 1'b0;
            r_reg.wakeIrq <= 1'b0;
            r_reg.resetReq <= 1'b0;
            r_reg.syncA <= '0;
            r_reg.syncB <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    // Clock enables follow state; restart phase powers the main oscillator back up, timer oscillator and async clock keep their sleep gating
    always_comb begin
        coreClkEn = 1'b1;
        progClkEn = 1'b1;
        periphClkEn = 1'b1;
        convClkEn = 1'b1;
        asyncClkEn = 1'b1;
        mainOscEn = 1'b1;
        timerOscEn = asyncTimerIsAsync;
        timerSyncClkEn = 1'b0;
        if (r_reg.state == ST_SLEEP) begin
            coreClkEn = gate[CE_CORE];
            progClkEn = gate[CE_PROG];
            periphClkEn = gate[CE_PERIPH];
            convClkEn = gate[CE_CONV];
            asyncClkEn = gate[CE_ASYNC];
            mainOscEn = gate[CE_MOSC];
            timerOscEn = gate[CE_TOSC];
            timerSyncClkEn = gate[CE_T2SYNC];
        end else if (r_reg.state == ST_START) begin
            coreClkEn = 1'b0;
            progClkEn = 1'b0;
            periphClkEn = 1'b0;
            convClkEn = 1'b0;
            asyncClkEn = gate[CE_ASYNC];
            timerOscEn = gate[CE_TOSC];
        end else if (r_reg.state == ST_HOLD) begin
            coreClkEn = 1'b0;
        end
    end

    // Status and pulse outputs
    assign ctrlRdData = {4'h0, r_reg.ctrl};
    assign coreHalt = (r_reg.state != ST_ACTIVE);
    assign sleeping = (r_reg.state == ST_SLEEP);
    assign convStart = r_reg.convStart;
    assign wakeIrq = r_reg.wakeIrq;
    assign resetReq = r_reg.resetReq;
endmodule : smc_sleep_ctrl
`default_nettype wire

/* File: smc_sleep_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module smc_sleep_sva (
    input wire logic                        core_clk,
    input wire logic                        rst_n,
    input wire logic                        ctrlWrEn,
    input wire logic [7:0]                  ctrlWrData,
    input wire logic [7:0]                  ctrlRdData,
    input wire logic                        sleepInstr,
    input wire logic [smc_pkg::CKSRC_W-1:0] clockSourceFuses,
    input wire logic                        converterEnabled,
    input wire logic                        coreClkEn,
    input wire logic                        progClkEn,
    input wire logic                        periphClkEn,
    input wire logic                        convClkEn,
    input wire logic                        mainOscEn,
    input wire logic                        timerOscEn,
    input wire logic                        coreHalt,
    input wire logic                        sleeping,
    input wire logic                        convStart,
    input wire logic                        wakeIrq,
    input wire logic                        resetReq
);
    logic [2:0] mode;
    logic [3:0] wrLow;
    // Mode as held in the control register, and the part of a write that is kept
    assign mode  = ctrlRdData[3:1];
    assign wrLow = ctrlWrData[3:0];
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    reg_write_a: assert property (ctrlWrEn |=> ctrlRdData == {4'h0, $past(wrLow)})
        else $error("control read-back differs from the write");
    no_sleep_a: assert property (sleepInstr && !coreHalt && (!ctrlRdData[0]
        || mode[2:1] == 2'b10) |=> !sleeping) else $error("sleep entered while not allowed");
    no_stby_a: assert property (sleepInstr && !coreHalt && mode[2:1] == 2'b11
        && clockSourceFuses < 4'h8 |=> !sleeping) else $error("standby without crystal");
    idle_gate_a: assert property (sleeping && mode == 3'b000 |-> !coreClkEn && !progClkEn
        && periphClkEn && convClkEn && mainOscEn) else $error("idle clock gating wrong");
    quiet_gate_a: assert property (sleeping && mode == 3'b001 |-> !periphClkEn && !coreClkEn
        && convClkEn && mainOscEn) else $error("quiet clock gating wrong");
    pdown_gate_a: assert property (sleeping && mode == 3'b010 |-> !(mainOscEn || convClkEn
        || periphClkEn || coreClkEn || timerOscEn)) else $error("power-down clock left on");
    stby_gate_a: assert property (sleeping && mode[2:1] == 2'b11 |-> mainOscEn
        && !convClkEn && !periphClkEn && !coreClkEn) else $error("standby gating wrong");
    conv_start_a: assert property ($rose(sleeping) |-> convStart ==
        (converterEnabled && mode[2:1] == 2'b00)) else $error("conversion start wrong");
    idle_wake_a: assert property ($fell(sleeping) && $past(rst_n) && $past(mode) <= 3'b001
        |-> coreHalt [*4] ##1 (wakeIrq || resetReq)) else $error("idle wake hold not four");
    stby_wake_a: assert property ($fell(sleeping) && $past(rst_n) && $past(mode) >= 3'b110
        |-> ##10 (wakeIrq || resetReq)) else $error("standby wake latency wrong");

    // Main scenarios reached
    cover property ($fell(sleeping) && $past(mode) == 3'b000);
    cover property ($fell(sleeping) && $past(mode) == 3'b111);
    cover property (resetReq);
endmodule : smc_sleep_sva

bind smc_sleep_ctrl smc_sleep_sva chk (.core_clk(core_clk), .rst_n(rst_n),
    .ctrlWrEn(ctrlWrEn), .ctrlWrData(ctrlWrData), .ctrlRdData(ctrlRdData),
    .sleepInstr(sleepInstr), .clockSourceFuses(clockSourceFuses),
    .converterEnabled(converterEnabled), .coreClkEn(coreClkEn), .progClkEn(progClkEn),
    .periphClkEn(periphClkEn), .convClkEn(convClkEn), .mainOscEn(mainOscEn),
    .timerOscEn(timerOscEn), .coreHalt(coreHalt), .sleeping(sleeping),
    .convStart(convStart), .wakeIrq(wakeIrq), .resetReq(resetReq));
`default_nettype wire

/* File: smc_wake_src.sv */
`timescale 1ns/100ps
`default_nettype none
module smc_wake_src (
    input  wire logic        core_clk,
    input  wire logic        sleeping,
    input  wire logic        raise,
    input  wire logic [3:0]  sel,
    output var  logic [14:0] wakeVec
);
    logic [14:0] wakeVec_reg = 15'h0000;
    logic [7:0]  holdCnt_reg = 8'h00;
    assign wakeVec = wakeVec_reg;
    // One request line, held until the core has left sleep or a cap runs out
    always @(posedge core_clk) begin
        if (raise) begin
            wakeVec_reg <= 15'h0001 << sel;
            holdCnt_reg <= 8'h00;
        end else if (wakeVec_reg != 15'h0000) begin
            holdCnt_reg <= holdCnt_reg + 8'h01;
            if ((!sleeping && holdCnt_reg > 8'h02) || holdCnt_reg == 8'h28) begin
                wakeVec_reg <= 15'h0000;
            end
        end
    end
endmodule : smc_wake_src
`default_nettype wire

/* File: smc_sleep_ctrl_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module smc_sleep_ctrl_bench;
    import smc_pkg::*;
    logic        core_clk = 1'b0, rst_n = 1'b0, ctrlWrEn = 1'b0, sleepInstr = 1'b0;
    logic [7:0]  ctrlWrData = 8'h00;
    logic [3:0]  fuses = 4'h0, sel = 4'h0;
    logic        irqOn = 1'b0, lvl = 1'b0, raise = 1'b0;
    logic        convEn = 1'b1, tAsync = 1'b1, tSync = 1'b0;
    logic [7:0]  ctrlRdData;
    logic [14:0] wv;
    logic        coreClkEn, progClkEn, periphClkEn, convClkEn, asyncClkEn, mainOscEn;
    logic        timerOscEn, timerSyncClkEn, coreHalt, sleeping, convStart, wakeIrq, resetReq;
    int          fail_count = 0, n_compared = 0, cycles = 0;

    // System clock
    always #2.5 core_clk = ~core_clk;

    smc_sleep_ctrl #(.STARTUP_FAST(16'h0008), .STARTUP_SLOW(16'h0014)) uut (
        .core_clk(core_clk), .rst_n(rst_n), .ctrlWrEn(ctrlWrEn), .ctrlWrData(ctrlWrData),
        .ctrlRdData(ctrlRdData), .sleepInstr(sleepInstr), .clockSourceFuses(fuses),
        .converterEnabled(convEn), .asyncTimerIsAsync(tAsync), .asyncTimerIsSync(tSync),
        .asyncTimerIrqMask({2{irqOn}}), .globalIrqEn(irqOn), .extIrqIsLevel({3{lvl}}),
        .extIrqLines(wv[2:0]), .pinChangeIrq(wv[3]), .twoWireMatch(wv[4]), .twoWireIrq(wv[5]),
        .watchdogIrq(wv[6]), .convDoneIrq(wv[7]), .nvReadyIrq(wv[8]), .asyncTimerOvf(wv[9]),
        .asyncTimerCmp(wv[10]), .otherIrq(wv[11]), .extResetReq(wv[12]),
        .watchdogResetReq(wv[13]), .brownOutResetReq(wv[14]), .coreClkEn(coreClkEn),
        .progClkEn(progClkEn), .periphClkEn(periphClkEn), .convClkEn(convClkEn),
        .asyncClkEn(asyncClkEn), .mainOscEn(mainOscEn), .timerOscEn(timerOscEn),
        .timerSyncClkEn(timerSyncClkEn), .coreHalt(coreHalt), .sleeping(sleeping),
        .convStart(convStart), .wakeIrq(wakeIrq), .resetReq(resetReq));

    smc_wake_src src (.core_clk(core_clk), .sleeping(sleeping), .raise(raise), .sel(sel),
        .wakeVec(wv));

    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t value %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic chkb(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t flag %b expected %b", $time, got, exp);
        end
    endtask : chkb

    // Expected enables while asleep: core, prog, periph, conv, async, main osc, timer osc, sync
    function automatic logic [7:0] gates(input logic [2:0] m, input logic a, input logic s);
        case (m)
            3'b000: return {6'b001111, a, 1'b0};
            3'b001: return {6'b000111, a, 1'b0};
            3'b011: return {4'h0, a, s, a, s};
            3'b110: return 8'h04;
            3'b111: return {4'h0, a, 1'b1, a, 1'b0};
            default: return 8'h00;
        endcase
    endfunction : gates

    task automatic wr(input logic [7:0] d);
        @(posedge core_clk);
        ctrlWrEn   <= 1'b1;
        ctrlWrData <= d;
        @(posedge core_clk);
        ctrlWrEn   <= 1'b0;
        @(negedge core_clk);
    endtask : wr

    task automatic raise_src(input logic [3:0] s);
        @(posedge core_clk);
        raise <= 1'b1;
        sel   <= s;
        @(posedge core_clk);
        raise <= 1'b0;
    endtask : raise_src

    task automatic wait_pulse();
        int n;
        n = 0;
        @(negedge core_clk);
        while (wakeIrq !== 1'b1 && resetReq !== 1'b1 && n < 60) begin
            @(negedge core_clk);
            n++;
        end
    endtask : wait_pulse

    // Program a mode, execute sleep, offer one wake source, fall back to a reset wake
    task automatic run(input logic [2:0] m, input logic se, input logic [3:0] f,
                       input logic [1:0] cfg, input logic [3:0] s, input logic sl,
                       input logic wk);
        @(posedge core_clk);
        fuses        <= f;
        {lvl, irqOn} <= cfg;
        wr({4'h0, m, se});
        @(posedge core_clk);
        sleepInstr <= 1'b1;
        @(posedge core_clk);
        sleepInstr <= 1'b0;
        @(negedge core_clk);
        chkb(sleeping, sl);
        chkb(convStart, sl && m[2:1] == 2'b00 && convEn);
        if (sl) begin
            chk({coreClkEn, progClkEn, periphClkEn, convClkEn, asyncClkEn, mainOscEn,
                timerOscEn, timerSyncClkEn}, gates(m, tAsync, tSync));
            raise_src(s);
            wait_pulse();
            chkb(wakeIrq, wk);
            if (wk) chk(ctrlRdData, {4'h0, m, se});
            if (!wk) begin
                raise_src(4'd12);
                wait_pulse();
                chkb(resetReq, 1'b1);
                repeat (2) @(negedge core_clk);
                chk(ctrlRdData, 8'h00);
            end
            @(negedge core_clk);
            chkb(coreClkEn, 1'b1);
            repeat (4) @(posedge core_clk);
        end
        wr(8'h00);
    endtask : run

    // Cycle ceiling against a hang
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 10000) begin
            fail_count++;
            stop_test();
        end
    end

    initial begin
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        @(negedge core_clk);
        chk(ctrlRdData, 8'h00);
        chk({coreClkEn, mainOscEn, timerOscEn, timerSyncClkEn, coreHalt, 3'h0}, 8'hE0);
        wr(8'hFF);
        chk(ctrlRdData, 8'h0F);
        run(3'b000, 1'b0, 4'h0, 2'b00, 4'd11, 1'b0, 1'b0);
        run(3'b100, 1'b1, 4'h0, 2'b00, 4'd11, 1'b0, 1'b0);
        run(3'b101, 1'b1, 4'h0, 2'b00, 4'd11, 1'b0, 1'b0);
        run(3'b110, 1'b1, 4'h0, 2'b00, 4'd3, 1'b0, 1'b0);
        run(3'b000, 1'b1, 4'h0, 2'b00, 4'd11, 1'b1, 1'b1);
        @(posedge core_clk);
        convEn <= 1'b0;
        run(3'b000, 1'b1, 4'h0, 2'b00, 4'd0, 1'b1, 1'b1);
        @(posedge core_clk);
        convEn <= 1'b1;
        run(3'b001, 1'b1, 4'h0, 2'b00, 4'd7, 1'b1, 1'b1);
        run(3'b001, 1'b1, 4'h0, 2'b00, 4'd11, 1'b1, 1'b0);
        run(3'b010, 1'b1, 4'h0, 2'b00, 4'd0, 1'b1, 1'b0);
        run(3'b010, 1'b1, 4'h0, 2'b10, 4'd0, 1'b1, 1'b1);
        run(3'b010, 1'b1, 4'h1, 2'b00, 4'd4, 1'b1, 1'b1);
        @(posedge core_clk);
        tAsync <= 1'b0;
        tSync  <= 1'b1;
        run(3'b011, 1'b1, 4'h0, 2'b01, 4'd9, 1'b1, 1'b1);
        @(posedge core_clk);
        tAsync <= 1'b1;
        tSync  <= 1'b0;
        run(3'b011, 1'b1, 4'h0, 2'b00, 4'd9, 1'b1, 1'b0);
        run(3'b110, 1'b1, 4'h8, 2'b00, 4'd3, 1'b1, 1'b1);
        run(3'b111, 1'b1, 4'h9, 2'b01, 4'd10, 1'b1, 1'b1);
        stop_test();
    end
endmodule : smc_sleep_ctrl_bench
`default_nettype wire
